//--- shared/pdu_cfg.svh
// Purpose: Offsets, field positions and reset values of the datapath cell
// Assumes: Included by the package and the design file
// Notes: Byte-wide register port, 6-bit address
`ifndef PDU_CFG_SVH
`define PDU_CFG_SVH
`define PDU_AW 6
`define PDU_DW 8
// Register offsets
`define PDU_A_A0 6'h00
`define PDU_A_A1 6'h01
`define PDU_A_D0 6'h02
`define PDU_A_D1 6'h03
`define PDU_SET_BIT 2
`define PDU_A_F0 6'h08
`define PDU_A_F1 6'h09
`define PDU_A_MASK0 6'h0a
`define PDU_A_MASK1 6'h0b
`define PDU_A_OMASK 6'h0c
`define PDU_A_MSB 6'h0d
`define PDU_A_POLY 6'h0e
`define PDU_A_CMPCFG 6'h0f
`define PDU_A_OSEL0 6'h10
`define PDU_A_OSEL1 6'h11
`define PDU_A_OSEL2 6'h12
`define PDU_A_MODE 6'h13
`define PDU_A_CTRL 6'h14
`define PDU_A_STATUS 6'h15
`define PDU_A_STICKY 6'h16
`define PDU_A_CLKEN 6'h17
`define PDU_A_FSTAT 6'h18
`define PDU_A_CFG_HI 1'b1
// Mode and clock enable bits
`define PDU_MODE_F0OUT 0
`define PDU_MODE_F1OUT 1
`define PDU_MODE_TMUX 2
`define PDU_MODE_CHAIN 3
`define PDU_CLK_DP 0
`define PDU_CLK_SC 1
// Reset values
`define PDU_RST_MSB 3'h7
`define PDU_RST_OMASK 8'hff
`define PDU_RST_CLKEN 4'hf
`define PDU_ZERO8 8'h00
`define PDU_ONES8 8'hff
// Condition vector positions
`define PDU_C_CE0 0
`define PDU_C_CL0 1
`define PDU_C_CE1 2
`define PDU_C_CL1 3
`define PDU_C_Z0 4
`define PDU_C_Z1 5
`define PDU_C_FF0 6
`define PDU_C_FF1 7
`define PDU_C_OV 8
`define PDU_C_CO 9
`define PDU_C_SO 10
`define PDU_C_F0E 11
`define PDU_C_F0F 12
`define PDU_C_F1E 13
`define PDU_C_F1F 14
`define PDU_C_CHCE 15
`endif

//--- shared/pdu_pkg.sv
// Purpose: Types shared by the datapath cell and its bench
// Assumes: pdu_cfg.svh holds the address and data widths
// Notes: Dynamic configuration word is 16 bits, two bus bytes
`include "pdu_cfg.svh"
package pdu_pkg;
  typedef enum logic [2:0] {
    PDU_F_PASS = 3'h0, PDU_F_ADD = 3'h1, PDU_F_SUB = 3'h2, PDU_F_INC = 3'h3,
    PDU_F_DEC = 3'h4, PDU_F_AND = 3'h5, PDU_F_OR = 3'h6, PDU_F_XOR = 3'h7
  } pdu_func_t;
  // Shift: none, left, right, CRC/PRS step
  typedef enum logic [1:0] {
    PDU_S_NONE = 2'h0, PDU_S_LEFT = 2'h1, PDU_S_RIGHT = 2'h2, PDU_S_CRC = 2'h3
  } pdu_shift_t;
  typedef struct packed {
    logic [2:0] spare;
    logic [1:0] dest;     // 0 none, 1 A0, 2 A1, 3 both
    logic [1:0] cin_sel;  // 0 zero, 1 one, 2 registered, 3 chain
    logic [1:0] sin_sel;  // 0 routed, 1 registered, 2 chain, 3 zero
    pdu_shift_t shift;
    logic srcb;           // 0 D0, 1 D1
    logic srca;           // 0 A0, 1 A1
    pdu_func_t func;
  } pdu_cfg_word_t;
  typedef struct packed {
    logic carry;
    logic shift;
    logic cond;
  } pdu_chain_t;
  typedef struct packed {
    logic [`PDU_AW-1:0] addr;
    logic [`PDU_DW-1:0] wdata;
    logic wr;
    logic rd;
  } pdu_bus_req_t;
endpackage : pdu_pkg

//--- design/pdu_datapath.sv
// Purpose: Programmable 8-bit datapath cell with status and control unit
// Assumes: Single clock, synchronous inputs, byte register port
// Notes: Behaviour
// Behaviour
// [RULE1] Two comparators, each with operand mask
// [RULE2] Compare operands from A0, A1, D0, D1 pairings
// [RULE3] Zero, all-ones and overflow conditions generated
// [RULE4] Conditions are outputs, selectable onto routing
// [RULE5] Programmable most significant bit position
// [RULE6] ALU result passes configurable output mask
// [RULE7] One CRC/PRS step per cycle, programmable polynomial
// [RULE8] Wider CRC/PRS by chaining to neighbour cells
// [RULE9] Two four-byte FIFOs, direction set independently
// [RULE10] Input: bus writes, datapath reads; output reversed
// [RULE11] FIFO status selectable as datapath outputs
// [RULE12] Carry, shift and conditions chain to neighbours
// [RULE13] Time multiplexing alternates two register/condition sets
// [RULE14] Carry and shift out registered, reusable later
// [RULE15] Registered carry gives double-width operations
// [RULE16] Six routed inputs and six routed outputs
// [RULE17] Routed inputs select operation and serial data
// [RULE18] Routed outputs select conditions or serial outputs
// [RULE19] Bus-written control bits drive into routing
// [RULE20] Status register read-only, from internal routing
// [RULE21] Sticky status bits latch, clear on read
// [RULE22] Each sub-block has its own clock enable
// [RULE23] FIFO empty/full; write to full ignored
// [RULE24] Datapath registers, pointers, status clear on reset
`timescale 1ns/1ns
`include "pdu_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Four-entry byte FIFO, flip-flop storage
module pdu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] data_out,
  output logic empty_out,
  output logic full_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // A push into a full FIFO is dropped so stored bytes stay intact
  assign do_push = push_in && !full_out; // [RULE23]
  assign do_pop = pop_in && !empty_out;
  assign empty_out = (cnt_q == '0); // [RULE23]
  assign full_out = (cnt_q == (PW+1)'(DEPTH)); // [RULE23]
  assign data_out = mem_q[rp_q];

  // Pointers and count
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wp_q <= '0; // [RULE24]
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  // Storage
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (do_push) begin
      mem_q[wp_q] <= data_in;
    end
  end
endmodule : pdu_fifo

////////////////////////////////////////////////////////////////////////////////
// Datapath cell top
module pdu_datapath #(
  parameter int NCFG = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [`PDU_AW-1:0] addr_in,
  input wire logic [`PDU_DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`PDU_DW-1:0] rdata_out,
  input wire logic [5:0] route_in,
  output logic [5:0] route_out,
  input wire pdu_pkg::pdu_chain_t chain_in,
  output pdu_pkg::pdu_chain_t chain_out,
  output logic [7:0] ctrl_out,
  input wire logic [7:0] status_in,
  output logic [1:0] pld_clk_en_out
);
  import pdu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Static configuration registers
  logic [7:0] mask_q [2];
  logic [7:0] omask_q;
  logic [2:0] msb_q;
  logic [7:0] poly_q;
  logic [3:0] cmpcfg_q;
  logic [3:0] osel_q [6];
  logic [3:0] mode_q;
  logic [3:0] clken_q;
  logic [7:0] ctrl_q;
  logic [7:0] sticky_q;
  logic [7:0] stat_q;
  logic [15:0] cfg_q [NCFG];
  logic bus_wr_cfg;
  logic dp_en;
  logic sc_en;
  logic tmux;

  assign bus_wr_cfg = wr_in && addr_in[`PDU_AW-1];
  assign dp_en = clken_q[`PDU_CLK_DP]; // [RULE22]
  assign sc_en = clken_q[`PDU_CLK_SC]; // [RULE22]
  assign pld_clk_en_out = clken_q[3:2]; // [RULE22]
  assign tmux = mode_q[`PDU_MODE_TMUX];
  assign ctrl_out = ctrl_q; // [RULE19]

  // Configuration writes; these fields are never touched by the datapath
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mask_q[0] <= `PDU_ONES8;
      mask_q[1] <= `PDU_ONES8;
      omask_q <= `PDU_RST_OMASK;
      msb_q <= `PDU_RST_MSB;
      poly_q <= `PDU_ZERO8;
      cmpcfg_q <= '0;
      mode_q <= '0;
      clken_q <= `PDU_RST_CLKEN;
      sticky_q <= `PDU_ZERO8;
      for (int i = 0; i < 6; i++) osel_q[i] <= '0;
    end else if (wr_in) begin
      unique case (addr_in)
        `PDU_A_MASK0: mask_q[0] <= wdata_in;
        `PDU_A_MASK1: mask_q[1] <= wdata_in;
        `PDU_A_OMASK: omask_q <= wdata_in;
        `PDU_A_MSB: msb_q <= wdata_in[2:0];
        `PDU_A_POLY: poly_q <= wdata_in;
        `PDU_A_CMPCFG: cmpcfg_q <= wdata_in[3:0];
        `PDU_A_MODE: mode_q <= wdata_in[3:0];
        `PDU_A_CLKEN: clken_q <= wdata_in[3:0];
        `PDU_A_STICKY: sticky_q <= wdata_in;
        `PDU_A_OSEL0: begin
          osel_q[0] <= wdata_in[3:0];
          osel_q[1] <= wdata_in[7:4];
        end
        `PDU_A_OSEL1: begin
          osel_q[2] <= wdata_in[3:0];
          osel_q[3] <= wdata_in[7:4];
        end
        `PDU_A_OSEL2: begin
          osel_q[4] <= wdata_in[3:0];
          osel_q[5] <= wdata_in[7:4];
        end
        default: ;
      endcase
    end
  end

  // Dynamic configuration store, two bytes per word
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < NCFG; i++) cfg_q[i] <= '0;
    end else if (bus_wr_cfg) begin
      if (addr_in[0] == `PDU_A_CFG_HI) cfg_q[addr_in[3:1]][15:8] <= wdata_in;
      else cfg_q[addr_in[3:1]][7:0] <= wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register sets and time multiplexing
  logic [7:0] a0_q [2];
  logic [7:0] a1_q [2];
  logic [7:0] d0_q [2];
  logic [7:0] d1_q [2];
  logic cy_q [2];
  logic so_q [2];
  logic [15:0] cond_q [2];
  logic phase_q;
  logic set;
  pdu_cfg_word_t cw;

  // In multiplexed mode the ALU serves set 0 and set 1 on alternate cycles
  assign set = tmux ? phase_q : 1'b0; // [RULE13]
  assign cw = pdu_cfg_word_t'(cfg_q[route_in[2:0]]); // [RULE17]

  always_ff @(posedge mclk_in) begin
    if (reset_in) phase_q <= 1'b0;
    else if (dp_en && tmux) phase_q <= !phase_q; // [RULE13]
    else if (!tmux) phase_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs, each side chosen by its direction bit
  logic f_out [2];
  logic f_push [2];
  logic f_pop [2];
  logic [7:0] f_wdata [2];
  logic [7:0] f_rdata [2];
  logic f_empty [2];
  logic f_full [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      f_out[i] = mode_q[i];
      // Input: bus pushes, datapath strobe pops; output: the reverse
      f_push[i] = f_out[i] ? (dp_en && route_in[4+i])
                           : (wr_in && addr_in == (`PDU_A_F0 + 6'(i))); // [RULE10]
      f_pop[i] = f_out[i] ? (rd_in && addr_in == (`PDU_A_F0 + 6'(i)))
                          : (dp_en && route_in[4+i]); // [RULE10]
      f_wdata[i] = f_out[i] ? (i == 0 ? a0_q[set] : a1_q[set]) : wdata_in;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_fifo
    pdu_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo ( // [RULE9]
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .push_in(f_push[g]),
      .data_in(f_wdata[g]),
      .pop_in(f_pop[g]),
      .data_out(f_rdata[g]),
      .empty_out(f_empty[g]),
      .full_out(f_full[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // ALU, variable top bit, shifter and CRC/PRS
  logic [7:0] wmask;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] addend;
  logic cin;
  logic sin;
  logic [8:0] sum;
  logic [7:0] alu;
  logic [7:0] shres;
  logic [7:0] res;
  logic cout;
  logic sout;
  logic ovf;
  logic fb;

  always_comb begin
    // Bits above the chosen top bit take no part in the arithmetic
    wmask = 8'((9'h2 << msb_q) - 9'h1); // [RULE5]
    opa = (cw.srca ? a1_q[set] : a0_q[set]) & wmask;
    opb = (cw.srcb ? d1_q[set] : d0_q[set]) & wmask;
    unique case (cw.cin_sel)
      2'h0: cin = 1'b0;
      2'h1: cin = 1'b1;
      2'h2: cin = cy_q[set]; // [RULE14] [RULE15]
      default: cin = chain_in.carry; // [RULE12]
    endcase
    unique case (cw.sin_sel)
      2'h0: sin = route_in[3]; // [RULE17]
      2'h1: sin = so_q[set]; // [RULE14]
      2'h2: sin = chain_in.shift; // [RULE12] [RULE8]
      default: sin = 1'b0;
    endcase
    unique case (cw.func)
      PDU_F_SUB: addend = ~opb & wmask;
      PDU_F_INC: addend = 8'h01;
      PDU_F_DEC: addend = wmask;
      default: addend = opb;
    endcase
    sum = {1'b0, opa} + {1'b0, addend}
        + {8'h00, (cw.func == PDU_F_ADD || cw.func == PDU_F_SUB) && cin};
    unique case (cw.func)
      PDU_F_PASS: alu = opa;
      PDU_F_AND: alu = opa & opb;
      PDU_F_OR: alu = opa | opb;
      PDU_F_XOR: alu = opa ^ opb;
      default: alu = sum[7:0] & wmask;
    endcase
    // Carry is taken one above the programmable top bit
    cout = sum[4'(msb_q) + 4'h1]; // [RULE5]
    ovf = (opa[msb_q] == addend[msb_q]) && (sum[msb_q] != opa[msb_q]); // [RULE3]
    fb = alu[msb_q] ^ sin;
    unique case (cw.shift)
      PDU_S_LEFT: begin
        shres = {alu[6:0], sin};
        sout = alu[msb_q];
      end
      PDU_S_RIGHT: begin
        shres = (alu >> 1) | ({7'h00, sin} << msb_q);
        sout = alu[0];
      end
      PDU_S_CRC: begin
        // One polynomial step per clock; fb feeds the next cell when chained
        shres = {alu[6:0], 1'b0} ^ (fb ? poly_q : `PDU_ZERO8); // [RULE7]
        sout = fb; // [RULE8]
      end
      default: begin
        shres = alu;
        sout = so_q[set];
      end
    endcase
    res = shres & wmask & omask_q; // [RULE6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions
  logic [7:0] cmp_l [2];
  logic [7:0] cmp_r [2];
  logic [15:0] cond_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (cmpcfg_q[2*i +: 2]) // [RULE2]
        2'h0: begin cmp_l[i] = a0_q[set]; cmp_r[i] = d0_q[set]; end
        2'h1: begin cmp_l[i] = a1_q[set]; cmp_r[i] = d1_q[set]; end
        2'h2: begin cmp_l[i] = a0_q[set]; cmp_r[i] = a1_q[set]; end
        default: begin cmp_l[i] = a0_q[set]; cmp_r[i] = d1_q[set]; end
      endcase
    end
    cond_d = '0;
    cond_d[`PDU_C_CE0] = (cmp_l[0] & mask_q[0]) == (cmp_r[0] & mask_q[0]); // [RULE1]
    cond_d[`PDU_C_CL0] = (cmp_l[0] & mask_q[0]) < (cmp_r[0] & mask_q[0]); // [RULE1]
    cond_d[`PDU_C_CE1] = (cmp_l[1] & mask_q[1]) == (cmp_r[1] & mask_q[1]); // [RULE1]
    cond_d[`PDU_C_CL1] = (cmp_l[1] & mask_q[1]) < (cmp_r[1] & mask_q[1]); // [RULE1]
    cond_d[`PDU_C_Z0] = (a0_q[set] & wmask) == `PDU_ZERO8; // [RULE3]
    cond_d[`PDU_C_Z1] = (a1_q[set] & wmask) == `PDU_ZERO8; // [RULE3]
    cond_d[`PDU_C_FF0] = (a0_q[set] & wmask) == wmask; // [RULE3]
    cond_d[`PDU_C_FF1] = (a1_q[set] & wmask) == wmask; // [RULE3]
    cond_d[`PDU_C_OV] = ovf && (cw.func == PDU_F_ADD || cw.func == PDU_F_SUB);
    cond_d[`PDU_C_CO] = cout;
    cond_d[`PDU_C_SO] = sout;
    cond_d[`PDU_C_F0E] = f_empty[0]; // [RULE11]
    cond_d[`PDU_C_F0F] = f_full[0]; // [RULE11]
    cond_d[`PDU_C_F1E] = f_empty[1]; // [RULE11]
    cond_d[`PDU_C_F1F] = f_full[1]; // [RULE11]
    // A wide compare is equal only if the neighbour also reports equal
    cond_d[`PDU_C_CHCE] = cond_d[`PDU_C_CE0] &&
                          (!mode_q[`PDU_MODE_CHAIN] || chain_in.cond); // [RULE12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath register update; a bus write to the same register wins
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int s = 0; s < 2; s++) begin
        a0_q[s] <= `PDU_ZERO8; // [RULE24]
        a1_q[s] <= `PDU_ZERO8;
        d0_q[s] <= `PDU_ZERO8;
        d1_q[s] <= `PDU_ZERO8;
        cy_q[s] <= 1'b0;
        so_q[s] <= 1'b0;
        cond_q[s] <= '0;
      end
    end else begin
      if (dp_en) begin
        if (cw.dest[0]) a0_q[set] <= res;
        if (cw.dest[1]) a1_q[set] <= res;
        if (!f_out[0] && f_pop[0]) d0_q[set] <= f_rdata[0]; // [RULE10]
        if (!f_out[1] && f_pop[1]) d1_q[set] <= f_rdata[1]; // [RULE10]
        cy_q[set] <= cout; // [RULE14]
        so_q[set] <= sout; // [RULE14]
        cond_q[set] <= cond_d; // [RULE13]
      end
      if (wr_in && addr_in[`PDU_AW-1:3] == '0) begin
        unique case (addr_in[1:0])
          2'h0: a0_q[addr_in[`PDU_SET_BIT]] <= wdata_in;
          2'h1: a1_q[addr_in[`PDU_SET_BIT]] <= wdata_in;
          2'h2: d0_q[addr_in[`PDU_SET_BIT]] <= wdata_in;
          default: d1_q[addr_in[`PDU_SET_BIT]] <= wdata_in;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routed and chained outputs, registered
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      route_out <= '0;
      chain_out <= '0;
    end else begin
      for (int i = 0; i < 6; i++) route_out[i] <= cond_d[osel_q[i]]; // [RULE4] [RULE16] [RULE18]
      chain_out.carry <= cout; // [RULE12]
      chain_out.shift <= sout; // [RULE12] [RULE8]
      chain_out.cond <= cond_d[`PDU_C_CHCE]; // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and control unit
  logic stat_rd;
  assign stat_rd = rd_in && addr_in == `PDU_A_STATUS;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_q <= `PDU_ZERO8; // [RULE24]
      stat_q <= `PDU_ZERO8;
    end else if (sc_en) begin
      if (wr_in && addr_in == `PDU_A_CTRL) ctrl_q <= wdata_in; // [RULE19]
      // Sticky bits: a new event in the reading cycle survives the clear
      for (int i = 0; i < 8; i++) begin
        if (sticky_q[i]) stat_q[i] <= status_in[i] || (stat_q[i] && !stat_rd); // [RULE21]
        else stat_q[i] <= status_in[i]; // [RULE20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_out <= `PDU_ZERO8;
    end else if (!rd_in) begin
      rdata_out <= `PDU_ZERO8;
    end else if (addr_in[`PDU_AW-1]) begin
      rdata_out <= addr_in[0] ? cfg_q[addr_in[3:1]][15:8] : cfg_q[addr_in[3:1]][7:0];
    end else if (addr_in[`PDU_AW-1:3] == '0) begin
      unique case (addr_in[1:0])
        2'h0: rdata_out <= a0_q[addr_in[`PDU_SET_BIT]];
        2'h1: rdata_out <= a1_q[addr_in[`PDU_SET_BIT]];
        2'h2: rdata_out <= d0_q[addr_in[`PDU_SET_BIT]];
        default: rdata_out <= d1_q[addr_in[`PDU_SET_BIT]];
      endcase
    end else begin
      unique case (addr_in)
        `PDU_A_F0: rdata_out <= (f_out[0] && !f_empty[0]) ? f_rdata[0] : `PDU_ZERO8;
        `PDU_A_F1: rdata_out <= (f_out[1] && !f_empty[1]) ? f_rdata[1] : `PDU_ZERO8;
        `PDU_A_MASK0: rdata_out <= mask_q[0];
        `PDU_A_MASK1: rdata_out <= mask_q[1];
        `PDU_A_OMASK: rdata_out <= omask_q;
        `PDU_A_MSB: rdata_out <= {5'h00, msb_q};
        `PDU_A_POLY: rdata_out <= poly_q;
        `PDU_A_CMPCFG: rdata_out <= {4'h0, cmpcfg_q};
        `PDU_A_OSEL0: rdata_out <= {osel_q[1], osel_q[0]};
        `PDU_A_OSEL1: rdata_out <= {osel_q[3], osel_q[2]};
        `PDU_A_OSEL2: rdata_out <= {osel_q[5], osel_q[4]};
        `PDU_A_MODE: rdata_out <= {4'h0, mode_q};
        `PDU_A_CTRL: rdata_out <= ctrl_q;
        `PDU_A_STATUS: rdata_out <= stat_q; // [RULE20]
        `PDU_A_STICKY: rdata_out <= sticky_q;
        `PDU_A_CLKEN: rdata_out <= {4'h0, clken_q};
        `PDU_A_FSTAT: rdata_out <= {4'h0, f_full[1], f_empty[1], f_full[0], f_empty[0]};
        default: rdata_out <= `PDU_ZERO8;
      endcase
    end
  end
endmodule : pdu_datapath

//--- dv/pdu_datapath_checker.sv
// Purpose: Port assertions for the datapath cell
// Assumes: Bus, status and reset contract of the cell
// Notes: Shadows the clock and sticky enables from bus writes
`timescale 1ns/1ns
`include "pdu_cfg.svh"
module pdu_datapath_checker #(
  parameter int NCFG = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [5:0] route_in,
  input wire logic [5:0] route_out,
  input wire pdu_pkg::pdu_chain_t chain_in,
  input wire pdu_pkg::pdu_chain_t chain_out,
  input wire logic [7:0] ctrl_out,
  input wire logic [7:0] status_in,
  input wire logic [1:0] pld_clk_en_out
);
  import pdu_pkg::*;
  logic sc_q;
  logic [7:0] sticky_q;
  // Enables are invisible at the ports, so follow the writes
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sc_q <= 1'b1;
      sticky_q <= 8'h00;
    end else if (wr_in && addr_in == `PDU_A_CLKEN) begin
      sc_q <= wdata_in[`PDU_CLK_SC];
    end else if (wr_in && addr_in == `PDU_A_STICKY) begin
      sticky_q <= wdata_in;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_ctrl_rd;
    rd_in && addr_in == `PDU_A_CTRL;
  endsequence
  sequence s_sticky_rd;
    rd_in && addr_in == `PDU_A_STATUS && sticky_q == 8'hff && sc_q;
  endsequence
  sequence s_plain_rd;
    rd_in && addr_in == `PDU_A_STATUS && sticky_q == 8'h00 && sc_q;
  endsequence
  // Read data stands for one cycle only
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_ctrl_read: assert property (s_ctrl_rd |=> rdata_out == $past(ctrl_out))
    else $error("control readback wrong");
  a_ctrl_write: assert property (wr_in && addr_in == `PDU_A_CTRL && sc_q
    |=> ctrl_out == $past(wdata_in)) else $error("control write lost");
  a_ctrl_hold: assert property (!(wr_in && addr_in == `PDU_A_CTRL && sc_q)
    |=> $stable(ctrl_out)) else $error("control changed unasked");
  a_clken_pld: assert property (wr_in && addr_in == `PDU_A_CLKEN
    |=> pld_clk_en_out == $past(wdata_in[3:2])) else $error("logic clock enables wrong");
  a_hole_read: assert property (rd_in && addr_in == 6'h1f |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_reset_zero: assert property ($fell(reset_in) |-> ctrl_out == 8'h00
    && rdata_out == 8'h00 && chain_out == 3'h0 && route_out == 6'h00)
    else $error("outputs not cleared by reset");
  a_status_follow: assert property (s_plain_rd ##0 ($past(sc_q)
    && !$past(reset_in) && $past(sticky_q) == 8'h00) |=> rdata_out == $past(status_in, 2))
    else $error("status does not follow routing");
  a_sticky_latch: assert property (s_sticky_rd ##0 ($past(sc_q)
    && !$past(reset_in) && $past(sticky_q) == 8'hff)
    |=> (rdata_out & $past(status_in, 2)) == $past(status_in, 2))
    else $error("sticky bit lost");
  a_sticky_clear: assert property (s_sticky_rd ##1 s_sticky_rd
    |=> rdata_out == $past(status_in, 2)) else $error("sticky bit not cleared by read");
endmodule : pdu_datapath_checker
bind pdu_datapath pdu_datapath_checker #(.NCFG(NCFG)) u_chk (.mclk_in(mclk_in),
  .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .route_in(route_in), .route_out(route_out),
  .chain_in(chain_in), .chain_out(chain_out), .ctrl_out(ctrl_out),
  .status_in(status_in), .pld_clk_en_out(pld_clk_en_out));

//--- dv/pdu_route_model.sv
// Purpose: Routing-side partner driving the cell's routed inputs
// Assumes: Tasks are called right after a rising edge
// Notes: Serial input stays low
`timescale 1ns/1ns
module pdu_route_model (
  input wire logic mclk_in,
  output logic [5:0] route_out,
  output pdu_pkg::pdu_chain_t chain_out,
  output logic [7:0] status_out
);
  import pdu_pkg::*;
  initial begin
    route_out = 6'h00;
    chain_out = '0;
    status_out = 8'h00;
  end
  // One operation select per cycle, then an idle cycle
  task automatic op(input logic [2:0] sel);
    route_out[2:0] <= sel;
    @(posedge mclk_in);
    route_out[2:0] <= 3'h0;
    @(posedge mclk_in);
  endtask : op
  // Datapath-side read of the input buffer
  task automatic pop0;
    route_out[4] <= 1'b1;
    @(posedge mclk_in);
    route_out[4] <= 1'b0;
  endtask : pop0
  // Routed status levels, held or pulsed
  task automatic stat(input logic [7:0] v);
    status_out <= v;
  endtask : stat
  task automatic pulse(input logic [7:0] v);
    status_out <= v;
    @(posedge mclk_in);
    status_out <= 8'h00;
  endtask : pulse
  // Chain levels
  task automatic link(input pdu_chain_t v);
    chain_out <= v;
  endtask : link
endmodule : pdu_route_model

//--- dv/pdu_datapath_bench.sv
// Purpose: Self-checking bench for the datapath cell
// Assumes: Register map and bus contract of the cell
// Notes: Each single access takes two cycles; the bus never waits
`timescale 1ns/1ns
`include "pdu_cfg.svh"
module pdu_datapath_bench;
  import pdu_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [5:0] addr_in = 6'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out, ctrl_out, status_in;
  logic [5:0] route_in, route_out;
  logic [1:0] pld_clk_en_out;
  pdu_chain_t chain_in, chain_out;
  logic [5:0] ra [9] = '{6'h0d, 6'h0c, 6'h17, 6'h13, 6'h00, 6'h0a, 6'h18, 6'h1f, 6'h14};
  logic [7:0] rv [9] = '{8'h07, 8'hff, 8'h0f, 8'h00, 8'h00, 8'hff, 8'h05, 8'h00, 8'h00};
  int n_mismatch = 0;
  int compares = 0;
  always #5 mclk_in = ~mclk_in;
  pdu_datapath #(.NCFG(8)) u_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .route_in(route_in), .route_out(route_out),
    .chain_in(chain_in), .chain_out(chain_out), .ctrl_out(ctrl_out),
    .status_in(status_in), .pld_clk_en_out(pld_clk_en_out));
  pdu_route_model u_far (.mclk_in(mclk_in), .route_out(route_in),
    .chain_out(chain_in), .status_out(status_in));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Gap cycle after the strobe keeps each strobe a clean pulse
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata_out, exp);
    @(posedge mclk_in);
  endtask : rd
  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // A run of about 120 cycles; reaching 5000 is a hang
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    $display("test reset done");
    wr(`PDU_A_CTRL, 8'h5a);
    chk("ctrl", ctrl_out, 8'h5a);
    rd(`PDU_A_CTRL, 8'h5a);
    wr(`PDU_A_CLKEN, 8'h09);
    chk("pld enables", {6'h00, pld_clk_en_out}, 8'h02);
    wr(`PDU_A_CTRL, 8'ha5);
    chk("ctrl gated", ctrl_out, 8'h5a);
    wr(`PDU_A_CLKEN, 8'h0f);
    u_far.stat(8'ha5);
    wr(`PDU_A_STATUS, 8'hff);
    rd(`PDU_A_STATUS, 8'ha5);
    u_far.stat(8'h00);
    wr(`PDU_A_STICKY, 8'hff);
    u_far.pulse(8'h3c);
    // Back-to-back reads: the first clears what it returns
    addr_in <= `PDU_A_STATUS;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk("sticky set", rdata_out, 8'h3c);
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk("sticky cleared", rdata_out, 8'h00);
    @(posedge mclk_in);
    $display("test control and status done");
    for (int i = 1; i <= 5; i++) begin
      wr(`PDU_A_F0, 8'(i * 17));
    end
    rd(`PDU_A_FSTAT, 8'h06);
    for (int i = 1; i <= 4; i++) begin
      u_far.pop0();
      rd(`PDU_A_D0, 8'(i * 17));
    end
    rd(`PDU_A_FSTAT, 8'h05);
    $display("test fifo done");
    wr(6'h22, 8'h01);
    wr(6'h23, 8'h08);
    wr(6'h24, 8'he0);
    wr(6'h25, 8'h09);
    wr(`PDU_A_MSB, 8'h03);
    wr(`PDU_A_OMASK, 8'h0f);
    wr(`PDU_A_A0, 8'h0e);
    wr(`PDU_A_D0, 8'h05);
    u_far.op(3'h1);
    rd(`PDU_A_A0, 8'h03);
    wr(`PDU_A_MSB, 8'h07);
    wr(`PDU_A_OMASK, 8'hff);
    wr(`PDU_A_POLY, 8'h07);
    wr(`PDU_A_A0, 8'h81);
    u_far.op(3'h2);
    rd(`PDU_A_A0, 8'h05);
    $display("test alu done");
    wr(`PDU_A_MODE, 8'h08);
    wr(`PDU_A_OSEL2, 8'hf0);
    wr(`PDU_A_OSEL0, 8'hb4);
    @(posedge mclk_in);
    #1;
    chk("route", {2'b00, route_out}, 8'h1e);
    u_far.link(3'h1);
    @(posedge mclk_in);
    #1;
    chk("chain", {2'b00, route_out}, 8'h3e);
    $display("test outputs done");
    end_of_test();
  end
endmodule : pdu_datapath_bench
